// file: core/lst_pkg.sv
// Purpose: types for the scan timing and reset block
// Assumes: nothing beyond the defs header
// Notes:   command codes are a plain strobe-and-data port
package lst_pkg;

  typedef enum logic [4:0] {
    LST_CMD_DISPLAY,
    LST_CMD_INVERSE,
    LST_CMD_ADC,
    LST_CMD_RMW,
    LST_CMD_SUPPLY,
    LST_CMD_STATIC,
    LST_CMD_DRIVER,
    LST_CMD_SERIAL,
    LST_CMD_COLUMN,
    LST_CMD_START_LINE,
    LST_CMD_PAGE,
    LST_CMD_CONTRAST,
    LST_CMD_DUTY,
    LST_CMD_BIAS,
    LST_CMD_BOOST,
    LST_CMD_LINE_INV,
    LST_CMD_SW_RESET
  } lst_cmd_t;

endpackage

// file: core/lst_reset_sync.sv
// Purpose: async-assert, sync-release reset plus post-release settle wait
// Assumes: rst_b is the hardware reset pin, active low
// Notes:   runReady rises a fixed settle time after the synced release
`timescale 1ns/10ps
`default_nettype none
`include "lst_scan_defs.svh"

module lst_reset_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  output var  logic runReady
);

  localparam int WAIT_HI = `LST_RESUME_CYC;
  localparam int WAIT_LO = `LST_RESUME_CYC - 1;
  localparam logic [7:0] WAIT_LAST = 8'(`LST_RESUME_CYC - 1);

  logic       relMeta;
  logic       relMid;
  logic       relDone;
  logic [7:0] settleCount;
  logic [7:0] next_settleCount;
  logic       next_runReady;

  // settle counter starts once the release has passed the chain
  always_comb begin
    next_settleCount = settleCount;
    next_runReady    = runReady;
    if (relDone && !runReady) begin
      next_settleCount = settleCount + 8'h01;
      next_runReady    = (settleCount == WAIT_LAST);
    end
  end

  // release chain: the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      relMeta     <= 1'b0;
      relMid      <= 1'b0;
      relDone     <= 1'b0;
      settleCount <= 8'h00;
      runReady    <= 1'b0;
    end else begin
      relMeta     <= 1'b1;
      relMid      <= relMeta;
      relDone     <= relMid;
      settleCount <= next_settleCount;
      runReady    <= next_runReady;
    end
  end

  property p_resume_late;
    @(posedge clk) disable iff (!rst_b) $rose(relDone) |-> ##WAIT_LO !runReady;
  endproperty
  a_resume_late: assert property (p_resume_late) else $error("scan resumed too early");

  property p_resume_on_time;
    @(posedge clk) disable iff (!rst_b) $rose(relDone) |-> ##WAIT_HI runReady;
  endproperty
  a_resume_on_time: assert property (p_resume_on_time) else $error("scan resumed late");

endmodule
`default_nettype wire

// file: core/lst_scan_defs.svh
// Purpose: shared constants for the scan timing and reset block
// Assumes: oscillator clock of 100 MHz (10 ns period)
// Notes:   offsets are absent, the block has no register bus
`ifndef LST_SCAN_DEFS_SVH
`define LST_SCAN_DEFS_SVH

`define LST_SEG_COUNT      132
`define LST_COM_COUNT      88

// timing
`define LST_CLK_PERIOD_NS  10
`define LST_RESUME_NS      1000
`define LST_RESUME_CYC     ((`LST_RESUME_NS + `LST_CLK_PERIOD_NS - 1) / `LST_CLK_PERIOD_NS)

// reset values
`define LST_COLUMN_RST     8'h00
`define LST_START_RST      8'h00
`define LST_PAGE_RST       4'h0
`define LST_CONTRAST_RST   8'hFF
`define LST_SERIAL_RST     8'h00
`define LST_LINE_INV_RST   6'h00

// duty codes: code k means 1/(8*(k+1)) duty
`define LST_DUTY_8         4'h0
`define LST_DUTY_16        4'h1
`define LST_DUTY_24        4'h2
`define LST_DUTY_32        4'h3
`define LST_DUTY_40        4'h4
`define LST_DUTY_48        4'h5
`define LST_DUTY_56        4'h6
`define LST_DUTY_64        4'h7
`define LST_DUTY_72        4'h8
`define LST_DUTY_80        4'h9
`define LST_DUTY_88        4'hA

// oscillator divide factor per duty
`define LST_DIV_8          6'h2C
`define LST_DIV_16         6'h16
`define LST_DIV_24         6'h0F
`define LST_DIV_32         6'h0B
`define LST_DIV_40         6'h09
`define LST_DIV_48         6'h07
`define LST_DIV_64         6'h06
`define LST_DIV_72         6'h05
`define LST_DIV_88         6'h04

// bias codes 0..6 mean 1/4..1/10; booster multiple in plain count
`define LST_BIAS_10        3'h6
`define LST_BOOST_5X       3'h5

`endif

// file: core/lst_scan_timing.sv
// Purpose: display line clock, line counter, latch, common scan and reset init
// Assumes: clk is the free-running oscillator, rst_b the hardware reset pin
// Notes:   ramLineData must return the line at ramLineAddr within one line
//
// Contract
// - Reset forces display off, normal, ADC normal, RMW off, supply off, drivers off.
// - Reset zeroes column counter, start line and page address.
// - Reset sets contrast FF, duty 1/88, bias 1/10, boost x5, line inversion 0.
// - Normal operation resumes 1 us after reset rises.
// - Oscillator and data bus pins untouched by hardware reset.
// - Software reset loads only address, start, contrast, duty, bias, boost, inversion.
// - Each common cycle latches one 132-bit RAM line for the segments.
// - Display on, inverse and static drive alter latched data only.
// - Line counter and latch strobe come from the line clock.
// - Latch transfer is independent of host RAM accesses.
// - Commons are scanned one per line clock by a shift register.
// - Output level combines pixel, common selection and frame alternation.
// - Frame alternation toggles per frame, or every n lines.
// - Inversion register holds n minus one; zero disables.
// - Line clock is oscillator divided by the duty-dependent factor.
// - Mask option sets common order; version B reverses it.
// - Supply off disables booster, regulator and followers together.
// - Straps gate booster and regulator; followers enabled whenever supply is on.
// - Line counter resets on frame signal change, counts once per line.
`timescale 1ns/10ps
`default_nettype none
`include "lst_scan_defs.svh"

module lst_scan_timing #(
  parameter bit MASK_REVERSE = 1'b0
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          cmdValid,
  input  wire lst_pkg::lst_cmd_t             cmdCode,
  input  wire logic [7:0]                    cmdData,
  input  wire logic [`LST_SEG_COUNT-1:0]     ramLineData,
  input  wire logic                          supply_strap_a,
  input  wire logic                          supply_strap_b,
  output var  logic [7:0]                    ramLineAddr,
  output var  logic                          line_scan_clock,
  output var  logic                          frame_alternation,
  output var  logic [`LST_SEG_COUNT-1:0]     segLevel,
  output var  logic [`LST_COM_COUNT-1:0]     comLevel,
  output var  logic                          boosterEn,
  output var  logic                          regulatorEn,
  output var  logic                          followerEn,
  output var  logic                          scanRunning,
  output var  logic                          displayOn,
  output var  logic                          inverseOn,
  output var  logic                          adcReverse,
  output var  logic                          rmwMode,
  output var  logic                          supplyOn,
  output var  logic                          staticOn,
  output var  logic                          driverOn,
  output var  logic [7:0]                    serialShift,
  output var  logic [7:0]                    columnAddr,
  output var  logic [7:0]                    startLine,
  output var  logic [3:0]                    pageAddr,
  output var  logic [7:0]                    contrast_level,
  output var  logic [3:0]                    dutySel,
  output var  logic [2:0]                    biasSel,
  output var  logic [2:0]                    boostMult,
  output var  logic [5:0]                    lineInvCount
);

  // oscillator cycles per line for a duty code
  function automatic logic [5:0] dutyDivide(input logic [3:0] duty);
    logic [5:0] div;
    div = `LST_DIV_88;
    unique case (duty)
      `LST_DUTY_8:                div = `LST_DIV_8;
      `LST_DUTY_16:               div = `LST_DIV_16;
      `LST_DUTY_24:               div = `LST_DIV_24;
      `LST_DUTY_32:               div = `LST_DIV_32;
      `LST_DUTY_40:               div = `LST_DIV_40;
      `LST_DUTY_48:               div = `LST_DIV_48;
      `LST_DUTY_56, `LST_DUTY_64: div = `LST_DIV_64;
      `LST_DUTY_72:               div = `LST_DIV_72;
      default:                    div = `LST_DIV_88;
    endcase
    return div;
  endfunction

  // lines per frame for a duty code
  function automatic logic [6:0] dutyLines(input logic [3:0] duty);
    return 7'((7'(duty) + 7'h01) << 3);
  endfunction

  logic                      runReady;
  logic                      next_displayOn, next_inverseOn, next_adcReverse, next_rmwMode;
  logic                      next_supplyOn, next_staticOn, next_driverOn;
  logic [7:0]                next_serialShift, next_columnAddr, next_startLine, next_contrast;
  logic [3:0]                next_pageAddr, next_dutySel;
  logic [2:0]                next_biasSel, next_boostMult;
  logic [5:0]                next_lineInvCount;
  logic [5:0]                divCount, next_divCount;
  logic [6:0]                lineCount, next_lineCount;
  logic [5:0]                invCount, next_invCount;
  logic                      frameSig, next_frameSig;
  logic                      next_frameAlt, next_lineClock;
  logic [7:0]                next_ramLineAddr;
  logic [`LST_COM_COUNT-1:0] comShift, next_comShift;
  logic [`LST_SEG_COUNT-1:0] latchData, next_latchData;
  logic [`LST_SEG_COUNT-1:0] segPix, segShown, next_segLevel;
  logic [`LST_COM_COUNT-1:0] comPad, next_comLevel;
  logic                      tick, lastLine;
  logic [1:0]                strapMeta, strapMid, strapLate, strapState, next_strapState;
  logic                      next_boosterEn, next_regulatorEn, next_followerEn;

  // settle gate; the oscillator itself is never stopped by reset
  lst_reset_sync u_reset_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .runReady (runReady)
  );

  // command decode; software reset touches address and analog settings only
  always_comb begin
    next_displayOn    = displayOn;
    next_inverseOn    = inverseOn;
    next_adcReverse   = adcReverse;
    next_rmwMode      = rmwMode;
    next_supplyOn     = supplyOn;
    next_staticOn     = staticOn;
    next_driverOn     = driverOn;
    next_serialShift  = serialShift;
    next_columnAddr   = columnAddr;
    next_startLine    = startLine;
    next_pageAddr     = pageAddr;
    next_contrast     = contrast_level;
    next_dutySel      = dutySel;
    next_biasSel      = biasSel;
    next_boostMult    = boostMult;
    next_lineInvCount = lineInvCount;
    if (cmdValid) begin
      unique case (cmdCode)
        lst_pkg::LST_CMD_DISPLAY:    next_displayOn = cmdData[0];
        lst_pkg::LST_CMD_INVERSE:    next_inverseOn = cmdData[0];
        lst_pkg::LST_CMD_ADC:        next_adcReverse = cmdData[0];
        lst_pkg::LST_CMD_RMW:        next_rmwMode = cmdData[0];
        lst_pkg::LST_CMD_SUPPLY:     next_supplyOn = cmdData[0];
        lst_pkg::LST_CMD_STATIC:     next_staticOn = cmdData[0];
        lst_pkg::LST_CMD_DRIVER:     next_driverOn = cmdData[0];
        lst_pkg::LST_CMD_SERIAL:     next_serialShift = cmdData;
        lst_pkg::LST_CMD_COLUMN:     next_columnAddr = cmdData;
        lst_pkg::LST_CMD_START_LINE: next_startLine = cmdData;
        lst_pkg::LST_CMD_PAGE:       next_pageAddr = cmdData[3:0];
        lst_pkg::LST_CMD_CONTRAST:   next_contrast = cmdData;
        lst_pkg::LST_CMD_DUTY: begin
          // unknown duty codes are dropped so the divider stays legal
          if (cmdData[3:0] <= `LST_DUTY_88) next_dutySel = cmdData[3:0];
        end
        lst_pkg::LST_CMD_BIAS: begin
          if (cmdData[2:0] <= `LST_BIAS_10) next_biasSel = cmdData[2:0];
        end
        lst_pkg::LST_CMD_BOOST:      next_boostMult = cmdData[2:0];
        lst_pkg::LST_CMD_LINE_INV:   next_lineInvCount = cmdData[5:0];
        lst_pkg::LST_CMD_SW_RESET: begin
          next_columnAddr   = `LST_COLUMN_RST;
          next_startLine    = `LST_START_RST;
          next_pageAddr     = `LST_PAGE_RST;
          next_contrast     = `LST_CONTRAST_RST;
          next_dutySel      = `LST_DUTY_88;
          next_biasSel      = `LST_BIAS_10;
          next_boostMult    = `LST_BOOST_5X;
          next_lineInvCount = `LST_LINE_INV_RST;
        end
        default: ;
      endcase
    end
  end

  // settings held at init values for as long as the pin stays low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      displayOn      <= 1'b0;
      inverseOn      <= 1'b0;
      adcReverse     <= 1'b0;
      rmwMode        <= 1'b0;
      supplyOn       <= 1'b0;
      staticOn       <= 1'b0;
      driverOn       <= 1'b0;
      serialShift    <= `LST_SERIAL_RST;
      columnAddr     <= `LST_COLUMN_RST;
      startLine      <= `LST_START_RST;
      pageAddr       <= `LST_PAGE_RST;
      contrast_level <= `LST_CONTRAST_RST;
      dutySel        <= `LST_DUTY_88;
      biasSel        <= `LST_BIAS_10;
      boostMult      <= `LST_BOOST_5X;
      lineInvCount   <= `LST_LINE_INV_RST;
    end else begin
      displayOn      <= next_displayOn;
      inverseOn      <= next_inverseOn;
      adcReverse     <= next_adcReverse;
      rmwMode        <= next_rmwMode;
      supplyOn       <= next_supplyOn;
      staticOn       <= next_staticOn;
      driverOn       <= next_driverOn;
      serialShift    <= next_serialShift;
      columnAddr     <= next_columnAddr;
      startLine      <= next_startLine;
      pageAddr       <= next_pageAddr;
      contrast_level <= next_contrast;
      dutySel        <= next_dutySel;
      biasSel        <= next_biasSel;
      boostMult      <= next_boostMult;
      lineInvCount   <= next_lineInvCount;
    end
  end

  // >= rather than == so a duty change mid-line cannot skip the wrap
  assign tick     = (divCount >= dutyDivide(dutySel) - 6'h01);
  assign lastLine = (lineCount >= dutyLines(dutySel) - 7'h01);

  // line timing: divider, line counter, latch, common shift, alternation
  always_comb begin
    next_divCount    = 6'h00;
    next_lineCount   = 7'h00;
    next_invCount    = 6'h00;
    next_frameSig    = 1'b0;
    next_frameAlt    = 1'b0;
    next_lineClock   = 1'b0;
    next_ramLineAddr = startLine;
    next_comShift    = '0;
    next_latchData   = '0;
    if (runReady) begin
      next_divCount    = tick ? 6'h00 : divCount + 6'h01;
      next_lineClock   = tick;
      next_lineCount   = lineCount;
      next_invCount    = invCount;
      next_frameSig    = frameSig;
      next_frameAlt    = frame_alternation;
      next_ramLineAddr = ramLineAddr;
      next_comShift    = comShift;
      next_latchData   = latchData;
      if (tick) begin
        // RAM port is read only here, so host writes never tear a line
        next_latchData = ramLineData;
        next_comShift  = (lineCount == 7'h00) ? `LST_COM_COUNT'(1) : comShift << 1;
        if (lastLine) begin
          next_frameSig  = ~frameSig;
          next_lineCount = 7'h00;
        end else begin
          next_lineCount = lineCount + 7'h01;
        end
        next_ramLineAddr = startLine + 8'(next_lineCount);
        if (lineInvCount != 6'h00) begin
          if (invCount >= lineInvCount) begin
            next_invCount = 6'h00;
            next_frameAlt = ~frame_alternation;
          end else begin
            next_invCount = invCount + 6'h01;
          end
        end else begin
          next_frameAlt = next_frameSig;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount          <= 6'h00;
      lineCount         <= 7'h00;
      invCount          <= 6'h00;
      frameSig          <= 1'b0;
      frame_alternation <= 1'b0;
      line_scan_clock   <= 1'b0;
      ramLineAddr       <= 8'h00;
      comShift          <= '0;
      latchData         <= '0;
    end else begin
      divCount          <= next_divCount;
      lineCount         <= next_lineCount;
      invCount          <= next_invCount;
      frameSig          <= next_frameSig;
      frame_alternation <= next_frameAlt;
      line_scan_clock   <= next_lineClock;
      ramLineAddr       <= next_ramLineAddr;
      comShift          <= next_comShift;
      latchData         <= next_latchData;
    end
  end

  // column direction and mask-option common order
  for (genvar i = 0; i < `LST_SEG_COUNT; i++) begin : g_seg
    assign segPix[i] = adcReverse ? latchData[`LST_SEG_COUNT-1-i] : latchData[i];
  end
  for (genvar j = 0; j < `LST_COM_COUNT; j++) begin : g_com
    assign comPad[j] = MASK_REVERSE ? comShift[`LST_COM_COUNT-1-j] : comShift[j];
  end

  // display modifiers act on latched bits, never on RAM contents
  assign segShown = ((segPix | {`LST_SEG_COUNT{staticOn}}) ^ {`LST_SEG_COUNT{inverseOn}})
                    & {`LST_SEG_COUNT{displayOn}};

  // level 1 picks the outer rail; drivers off pulls every level low
  always_comb begin
    next_segLevel = '0;
    next_comLevel = '0;
    if (driverOn) begin
      next_segLevel = segShown ^ {`LST_SEG_COUNT{frame_alternation}};
      next_comLevel = comPad ^ {`LST_COM_COUNT{~frame_alternation}};
    end
    // strap pins settle once the second and third stages agree
    next_strapState  = (~(strapMid ^ strapLate) & strapLate)
                       | ((strapMid ^ strapLate) & strapState);
    next_boosterEn   = supplyOn & ~strapState[0];
    next_regulatorEn = supplyOn & ~(strapState[0] & strapState[1]);
    next_followerEn  = supplyOn;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      segLevel    <= '0;
      comLevel    <= '0;
      strapMeta   <= 2'h0;
      strapMid    <= 2'h0;
      strapLate   <= 2'h0;
      strapState  <= 2'h0;
      boosterEn   <= 1'b0;
      regulatorEn <= 1'b0;
      followerEn  <= 1'b0;
      scanRunning <= 1'b0;
    end else begin
      segLevel    <= next_segLevel;
      comLevel    <= next_comLevel;
      strapMeta   <= {supply_strap_b, supply_strap_a};
      strapMid    <= strapMeta;
      strapLate   <= strapMid;
      strapState  <= next_strapState;
      boosterEn   <= next_boosterEn;
      regulatorEn <= next_regulatorEn;
      followerEn  <= next_followerEn;
      scanRunning <= runReady;
    end
  end

  property p_reset_flags;
    @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> !displayOn && !inverseOn && !adcReverse && !rmwMode && !supplyOn
                       && !staticOn && !driverOn && serialShift == 8'h00;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not cleared by reset");

  property p_reset_addr;
    @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> columnAddr == 8'h00 && startLine == 8'h00 && pageAddr == 4'h0;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("addresses not cleared");

  property p_reset_analog;
    @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> contrast_level == 8'hFF && dutySel == 4'hA && biasSel == 3'h6
                       && boostMult == 3'h5 && lineInvCount == 6'h00;
  endproperty
  a_reset_analog: assert property (p_reset_analog) else $error("analog init wrong");

  property p_sw_reset;
    @(posedge clk) disable iff (!rst_b)
      cmdValid && cmdCode == lst_pkg::LST_CMD_SW_RESET |=> contrast_level == 8'hFF
      && dutySel == 4'hA && columnAddr == 8'h00 && displayOn == $past(displayOn)
      && supplyOn == $past(supplyOn);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset scope wrong");

  property p_latch;
    @(posedge clk) disable iff (!rst_b)
      runReady && tick |=> latchData == $past(ramLineData) && line_scan_clock;
  endproperty
  a_latch: assert property (p_latch) else $error("line not latched on line clock");

  // quiet for three more edges, as a duty change there would move the next tick
  property p_divide_88;
    @(posedge clk) disable iff (!rst_b)
      runReady && tick && dutySel == 4'hA && !cmdValid ##1 (!cmdValid)[*3]
      |-> !line_scan_clock && !$past(line_scan_clock) ##1 !line_scan_clock ##1 line_scan_clock;
  endproperty
  a_divide_88: assert property (p_divide_88) else $error("line clock divide wrong");

  property p_line_restart;
    @(posedge clk) disable iff (!rst_b) $changed(frameSig) |-> lineCount == 7'h00;
  endproperty
  a_line_restart: assert property (p_line_restart) else $error("line count not restarted");

  property p_com_onehot;
    @(posedge clk) disable iff (!rst_b) $onehot0(comShift);
  endproperty
  a_com_onehot: assert property (p_com_onehot) else $error("more than one common selected");

  property p_strap_gate;
    @(posedge clk) disable iff (!rst_b)
      strapState == 2'h3 |=> !regulatorEn && !boosterEn && followerEn == $past(supplyOn);
  endproperty
  a_strap_gate: assert property (p_strap_gate) else $error("strap gating wrong");

endmodule
`default_nettype wire

// file: verification/lst_panel_model.sv
// Purpose: panel side model watching the common electrodes
// Assumes: a common is selected when its level differs from ~frame_alternation
// Notes:   passive; the panel only loads the drivers
`timescale 1ns/10ps
`default_nettype none
`include "lst_scan_defs.svh"
module lst_panel_model (
  input  wire logic [`LST_COM_COUNT-1:0] comLevel,
  input  wire logic                      frame_alternation,
  output var  logic                      comOk
);
  // exactly one electrode at the select level, else rows would blur
  always_comb begin
    comOk = $onehot(comLevel ^ {`LST_COM_COUNT{~frame_alternation}});
  end
endmodule
`default_nettype wire

// file: verification/tb_lst_scan_timing.sv
// Purpose: self-checking bench for the scan timing and reset block
// Assumes: 100 MHz clock, random data from a fixed seed
// Notes:   ram data held constant so the latched line is known
`timescale 1ns/10ps
`default_nettype none
`include "lst_scan_defs.svh"
module tb_lst_scan_timing;
  logic clk = 0, rst_b = 0, cmdValid = 0, supply_strap_a = 0, supply_strap_b = 0;
  lst_pkg::lst_cmd_t cmdCode = lst_pkg::LST_CMD_DISPLAY;
  logic [7:0] cmdData = 8'h00, serialShift, columnAddr, startLine, contrast_level, ramLineAddr;
  logic [131:0] ramLineData = '0, d;
  logic [87:0] comLevel;
  logic [3:0] pageAddr, dutySel;
  logic [2:0] biasSel, boostMult;
  logic [5:0] lineInvCount;
  logic line_scan_clock, frame_alternation, boosterEn, regulatorEn, followerEn, scanRunning;
  logic displayOn, inverseOn, adcReverse, rmwMode, supplyOn, staticOn, driverOn, comOk;
  int n_mismatch = 0, checked = 0, n, k;
  always #5 clk = ~clk;
  lst_scan_timing lst_scan_timing_i (.clk, .rst_b, .cmdValid, .cmdCode, .cmdData,
    .ramLineData, .supply_strap_a, .supply_strap_b, .ramLineAddr, .line_scan_clock,
    .frame_alternation, .segLevel(), .comLevel, .boosterEn, .regulatorEn, .followerEn,
    .scanRunning, .displayOn, .inverseOn, .adcReverse, .rmwMode, .supplyOn, .staticOn,
    .driverOn, .serialShift, .columnAddr, .startLine, .pageAddr, .contrast_level,
    .dutySel, .biasSel, .boostMult, .lineInvCount);
  lst_panel_model lst_panel_model_i (.comLevel, .frame_alternation, .comOk);
  task cmp(input string nm, input logic [131:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task cmd(input lst_pkg::lst_cmd_t c, input logic [7:0] v);
    @(posedge clk) begin cmdValid <= 1; cmdCode <= c; cmdData <= v; end
    @(posedge clk) cmdValid <= 0;
    @(negedge clk);
  endtask
  // cycles between two line pulses
  task gap(output int g);
    g = 0;
    while (line_scan_clock !== 1'b1) @(negedge clk);
    do begin @(negedge clk); g++; end while (line_scan_clock !== 1'b1 && g < 99);
  endtask
  // line pulses between two alternation edges
  task frgap(output int g);
    logic f;
    g = 0;
    f = frame_alternation;
    while (frame_alternation === f) @(negedge clk);
    f = frame_alternation;
    while (frame_alternation === f && g < 99) begin
      @(negedge clk);
      if (line_scan_clock === 1'b1) g++;
    end
  endtask
  task chk_init();
    cmp("flags", 0, {displayOn, inverseOn, adcReverse, rmwMode, supplyOn, staticOn,
      driverOn, serialShift});
    cmp("addr", 0, {columnAddr, startLine, pageAddr});
    cmp("setup", {8'hFF, 4'hA, 3'h6, 3'h5, 6'h0}, {contrast_level, dutySel, biasSel,
      boostMult, lineInvCount});
  endtask
  function automatic int div_of(input int c);
    int t[11] = '{44, 22, 15, 11, 9, 7, 6, 6, 5, 4, 4};
    return t[c];
  endfunction
  task wrap_up();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog sized well above the expected run of a few thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // release reset, then time the settle wait up to the running flag
  task resume_chk();
    n = 0;
    @(posedge clk) rst_b <= 1;
    while (scanRunning !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    cmp("resume", 1, n inside {[100:110]});
  endtask
  initial begin
    void'($urandom(32'hbfb13151));
    repeat (16) @(posedge clk); // power-on reset
    chk_init();
    resume_chk();
    // flags survive the software reset, settings do not
    cmd(lst_pkg::LST_CMD_DISPLAY, 1);
    cmd(lst_pkg::LST_CMD_CONTRAST, 8'($urandom));
    cmd(lst_pkg::LST_CMD_PAGE, 8'h05);
    cmd(lst_pkg::LST_CMD_BOOST, 8'h03);
    cmd(lst_pkg::LST_CMD_BIAS, 8'h07);
    cmp("bias refused", 3'h6, biasSel);
    cmd(lst_pkg::LST_CMD_SW_RESET, 0);
    cmp("sw flags", 1, displayOn);
    cmp("sw set", {8'hFF, 4'h0, 3'h5}, {contrast_level, pageAddr, boostMult});
    // every duty code, plus one out of range that leaves 1/88 in place
    for (k = 0; k < 12; k++) begin
      cmd(lst_pkg::LST_CMD_DUTY, 8'(k));
      gap(n);
      gap(n);
      cmp("line period", div_of(k > 10 ? 10 : k), n);
    end
    cmd(lst_pkg::LST_CMD_DUTY, 0);
    k = $urandom % 256;
    cmd(lst_pkg::LST_CMD_START_LINE, 8'(k));
    frgap(n);
    frgap(n);
    cmp("frame lines", 8, n);
    cmp("line addr", k, ramLineAddr);
    cmd(lst_pkg::LST_CMD_DUTY, 8'h0A);
    cmd(lst_pkg::LST_CMD_LINE_INV, 6);
    frgap(n);
    frgap(n);
    cmp("inv lines", 7, n);
    // pixel path: normal, inverse, static, then display off
    cmd(lst_pkg::LST_CMD_DRIVER, 1);
    d = 132'({$urandom, $urandom, $urandom, $urandom, $urandom});
    @(posedge clk) ramLineData <= d;
    for (k = 0; k < 4; k++) begin
      if (k == 1) cmd(lst_pkg::LST_CMD_INVERSE, 1);
      if (k == 2) begin cmd(lst_pkg::LST_CMD_INVERSE, 0); cmd(lst_pkg::LST_CMD_STATIC, 1); end
      if (k == 3) begin cmd(lst_pkg::LST_CMD_STATIC, 0); cmd(lst_pkg::LST_CMD_DISPLAY, 0); end
      gap(n);
      gap(n);
      repeat (2) @(negedge clk);
      cmp("seg", k == 0 ? d : k == 1 ? ~d : k == 2 ? ~132'h0 : 132'h0,
        lst_scan_timing_i.segLevel ^ {132{frame_alternation}});
      cmp("com", 1, comOk);
    end
    cmd(lst_pkg::LST_CMD_SUPPLY, 1);
    for (k = 0; k < 4; k++) begin
      @(posedge clk) {supply_strap_a, supply_strap_b} <= 2'(k);
      repeat (8) @(negedge clk);
      cmp("straps", k < 2 ? 3'h7 : k == 2 ? 3'h3 : 3'h1,
        {boosterEn, regulatorEn, followerEn});
    end
    cmd(lst_pkg::LST_CMD_SUPPLY, 0);
    @(negedge clk); // enables follow supplyOn one edge later
    cmp("supply off", 0, {boosterEn, regulatorEn, followerEn});
    // modes set before the mid-run reset so that reset has work to undo
    cmd(lst_pkg::LST_CMD_ADC, 1);
    cmd(lst_pkg::LST_CMD_RMW, 1);
    cmd(lst_pkg::LST_CMD_SERIAL, 8'h5A);
    cmd(lst_pkg::LST_CMD_COLUMN, 8'h21);
    cmp("modes", {2'h3, 16'h5A21}, {adcReverse, rmwMode, serialShift, columnAddr});
    // second reset in mid-run, held past the minimum low time, then released
    @(posedge clk) rst_b <= 0;
    repeat (4) @(negedge clk);
    chk_init();
    repeat (1000) @(posedge clk); // straps high, outside supply up
    resume_chk();
    cmp("supply reset", 0, {boosterEn, regulatorEn, followerEn});
    wrap_up();
  end
endmodule
`default_nettype wire
